/* File: hw/oscsel_top.sv */
// oscillator source selection, start-up gating, pll and rc control
// Functional notes
// - reset decodes group select into four groups
// - primary choice decodes into nine oscillator modes
// - second pin function follows primary choice always
// - first oscillator pin never becomes general I/O
// - hold oscillator clock for 1024 cycles
// - start-up count only for crystal modes
// - secondary crystal runs whenever enabled, even asleep
// - secondary clock used only group 00, enabled
// - pll gain four, eight or sixteen
// - read-only lock bit follows pll lock
// - group 01 runs from fast rc
// - trim split over bits 15:14, 11:10
// - trim is signed 1.5 percent step count
// - low power rc always starts at power-on
// - low power rc kept only if needed
// - low power rc clocks timers, nominal 512 kHz
// - reset loads current and new group
// - current group read-only, shows group loaded at reset, 00 even while fast rc stands in
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "oscsel_consts.svh"
module oscsel_top
  import oscsel_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys,          // system clock, 100 MHz
  input  wire logic              rst_n,            // async reset, active low
  input  wire logic              por_bor_pulse,    // power-on or brown-out reset event
  input  wire logic              sleep_wake,       // wake from sleep event
  input  wire logic              sleep_active,     // device is asleep
  input  wire logic [1:0]        group_select_cfg, // group configuration field
  input  wire logic [3:0]        primary_choice_cfg, // primary choice field
  input  wire logic              osc_tick,         // one pulse per oscillator cycle
  input  wire logic              pll_locked,       // raw lock from the pll
  input  wire logic              powerup_expired,  // power-up timer has run out
  input  wire logic              fsm_enabled,      // fail-safe monitor enabled
  input  wire logic              wdt_enabled,      // watchdog enabled
  input  wire logic              psel,             // apb select
  input  wire logic              penable,          // apb enable
  input  wire logic              pwrite,           // apb write
  input  wire logic [ADDR_W-1:0] paddr,            // apb byte address
  input  wire logic [31:0]       pwdata,           // apb write data
  output logic                   pready,           // apb ready
  output logic [31:0]            prdata,           // apb read data
  output logic                   pslverr,          // apb error
  output logic [1:0]             clk_src_sel,      // group driving the device clock
  output logic                   osc_clk_release,  // oscillator clock passed on
  output logic                   pll_enable,       // pll in use
  output logic [4:0]             pll_gain,         // pll multiplier
  output logic                   sec_osc_run,      // secondary crystal running
  output logic                   low_power_rc_run,         // low power rc running
  output logic [3:0]             fast_rc_trim_out, // trim to the fast rc
  output logic                   osc_in_gpio_en,   // first pin as gpio
  output logic                   osc_out_drv_n,    // second pin output enable, low = drive
  output logic [1:0]             osc_out_func      // second pin function
);

  // ============================================================
  // decode helpers
  function automatic oscsel_mode_t decode_primary(input logic [3:0] c);
    oscsel_mode_t m;
    m = OSCSEL_M_BAD;
    casez (c)
      4'b1011: m = OSCSEL_M_EXT;
      4'b1100: m = OSCSEL_M_EXT_IO;
      4'b1101, 4'b1110, 4'b1111: m = OSCSEL_M_EXT_PLL;
      4'b1001: m = OSCSEL_M_RC;
      4'b1000: m = OSCSEL_M_RC_IO;
      4'b0100: m = OSCSEL_M_XTAL;
      4'b0101, 4'b0110, 4'b0111: m = OSCSEL_M_XTAL_PLL;
      4'b000?: m = OSCSEL_M_XTAL_LOW;
      4'b001?: m = OSCSEL_M_XTAL_HS;
      default: m = OSCSEL_M_BAD;
    endcase
    return m;
  endfunction

  // low two bits pick 4x, 8x or 16x in pll encodings
  function automatic logic [4:0] gain_of(input logic [1:0] g);
    logic [4:0] r;
    r = 5'h01;
    case (g)
      2'h1:    r = 5'h04;
      2'h2:    r = 5'h08;
      2'h3:    r = 5'h10;
      default: r = 5'h01;
    endcase
    return r;
  endfunction

  function automatic logic is_crystal(input oscsel_mode_t m);
    return (m == OSCSEL_M_XTAL) || (m == OSCSEL_M_XTAL_PLL) ||
           (m == OSCSEL_M_XTAL_LOW) || (m == OSCSEL_M_XTAL_HS);
  endfunction

  // ============================================================
  // state
  logic [1:0]   cur_group_r;
  logic [1:0]   new_group_r;
  logic [3:0]   prim_r;
  logic [3:0]   trim_r;
  logic         sec_en_r;
  logic         lock_r;
  logic         low_power_rc_r;
  logic         need_ost;
  logic         need_ost_cfg;
  oscsel_mode_t mode;

  oscsel_ost_if ost ();

  oscsel_startup_timer #(
    .CNT_W (10)
  ) u_ost (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ost     (ost)
  );

  assign mode = decode_primary(prim_r);

  // ============================================================
  // configuration capture at power-on / brown-out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_group_r <= `OSCSEL_GRP_FAST_RC;
      new_group_r <= `OSCSEL_GRP_FAST_RC;
      prim_r      <= 4'h0;
    end else if (por_bor_pulse) begin
      cur_group_r <= group_select_cfg;
      new_group_r <= group_select_cfg;
      prim_r      <= primary_choice_cfg;
    end
  end

  // start-up count only for crystal oscillators that must restart
  assign need_ost = (cur_group_r == `OSCSEL_GRP_SEC) ||
                    ((cur_group_r == `OSCSEL_GRP_PRIMARY) && is_crystal(mode));
  // a load is judged by the incoming fields, a wake by the group already held
  assign need_ost_cfg = (group_select_cfg == `OSCSEL_GRP_SEC) ||
                        ((group_select_cfg == `OSCSEL_GRP_PRIMARY) &&
                         is_crystal(decode_primary(primary_choice_cfg)));
  assign ost.start    = (por_bor_pulse && need_ost_cfg) || (sleep_wake && need_ost);
  assign ost.osc_tick = osc_tick;

  // ============================================================
  // clock release and selection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_clk_release <= 1'b0;
      clk_src_sel     <= `OSCSEL_GRP_FAST_RC;
    end else begin
      // held while counting or before any start on a crystal group
      osc_clk_release <= (por_bor_pulse || ost.start) ? 1'b0 : (!need_ost || ost.done);
      if (cur_group_r == `OSCSEL_GRP_SEC && !sec_en_r) begin
        // secondary not enabled: it cannot be the device clock
        clk_src_sel <= `OSCSEL_GRP_FAST_RC;
      end else begin
        clk_src_sel <= cur_group_r;
      end
    end
  end

  // ============================================================
  // pll
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_enable <= 1'b0;
      pll_gain   <= 5'h01;
      lock_r     <= 1'b0;
    end else begin
      pll_enable <= (cur_group_r == `OSCSEL_GRP_PRIMARY) &&
                    ((mode == OSCSEL_M_EXT_PLL) || (mode == OSCSEL_M_XTAL_PLL));
      pll_gain   <= gain_of(prim_r[1:0]);
      lock_r     <= pll_locked && pll_enable;
    end
  end

  // ============================================================
  // oscillator pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_out_func   <= OSCSEL_P2_XDRIVE;
      osc_out_drv_n  <= 1'b1;
      osc_in_gpio_en <= 1'b0;
    end else begin
      osc_in_gpio_en <= 1'b0;
      // follows the primary choice whatever group is in use
      case (mode)
        OSCSEL_M_EXT, OSCSEL_M_RC: begin
          osc_out_func  <= OSCSEL_P2_CLKDIV4;
          osc_out_drv_n <= 1'b0;
        end
        OSCSEL_M_EXT_IO, OSCSEL_M_EXT_PLL, OSCSEL_M_RC_IO: begin
          osc_out_func  <= OSCSEL_P2_GPIO;
          osc_out_drv_n <= 1'b1;
        end
        default: begin
          osc_out_func  <= OSCSEL_P2_XDRIVE;
          osc_out_drv_n <= 1'b1;
        end
      endcase
    end
  end

  // ============================================================
  // rc and secondary oscillator enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_power_rc_r <= 1'b1;
    end else if (por_bor_pulse || !powerup_expired) begin
      low_power_rc_r <= 1'b1;
    end else begin
      low_power_rc_r <= fsm_enabled || wdt_enabled ||
                (cur_group_r == `OSCSEL_GRP_LOW_POWER_RC);
    end
  end

  assign low_power_rc_run = low_power_rc_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_osc_run      <= 1'b0;
      fast_rc_trim_out <= `OSCSEL_TRIM_RST;
    end else begin
      // sleep does not stop it
      sec_osc_run      <= sec_en_r;
      fast_rc_trim_out <= trim_r;
    end
  end

  // ============================================================
  // apb slave: zero wait states
  logic        wr_en;
  logic        rd_en;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] fast_word;
  logic        hit;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign hit   = (paddr == `OSCSEL_CTRL_OFS) || (paddr == `OSCSEL_STAT_OFS) ||
                 (paddr == `OSCSEL_FAST_RC_OFS);

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[`OSCSEL_TRIM_HI_MSB:`OSCSEL_TRIM_HI_LSB] = trim_r[3:2];
    ctrl_word[`OSCSEL_CUR_GRP_MSB:`OSCSEL_CUR_GRP_LSB] = cur_group_r;
    ctrl_word[`OSCSEL_TRIM_LO_MSB:`OSCSEL_TRIM_LO_LSB] = trim_r[1:0];
    ctrl_word[`OSCSEL_NEW_GRP_MSB:`OSCSEL_NEW_GRP_LSB] = new_group_r;
    ctrl_word[`OSCSEL_LOCK_BIT]   = lock_r;
    ctrl_word[`OSCSEL_SEC_EN_BIT] = sec_en_r;
    stat_word = 32'h0;
    stat_word[`OSCSEL_ST_RELEASED_BIT] = osc_clk_release;
    stat_word[`OSCSEL_ST_LOW_POWER_RC_ON_BIT]  = low_power_rc_r;
    stat_word[`OSCSEL_ST_SEC_RUN_BIT]  = sec_osc_run;
    stat_word[`OSCSEL_ST_COUNTING_BIT] = ost.counting;
    // signed trim: frequency offset in tenths of a percent
    fast_word = 32'(signed'(trim_r) * `OSCSEL_TRIM_STEP_PERMIL);
  end

  // writable fields; current group, new group and lock stay read-only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trim_r   <= `OSCSEL_TRIM_RST;
      sec_en_r <= 1'b0;
    end else if (wr_en && paddr == `OSCSEL_CTRL_OFS) begin
      trim_r   <= {pwdata[`OSCSEL_TRIM_HI_MSB:`OSCSEL_TRIM_HI_LSB],
                   pwdata[`OSCSEL_TRIM_LO_MSB:`OSCSEL_TRIM_LO_LSB]};
      sec_en_r <= pwdata[`OSCSEL_SEC_EN_BIT];
    end
  end

  // read data registered in setup so it stands in the access phase
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd_en) begin
        case (paddr)
          `OSCSEL_CTRL_OFS:    prdata <= ctrl_word;
          `OSCSEL_STAT_OFS:    prdata <= stat_word;
          `OSCSEL_FAST_RC_OFS: prdata <= fast_word;
          default:             prdata <= 32'h0;
        endcase
      end else if (!psel) begin
        prdata <= 32'h0;
      end
    end
  end

endmodule

/* File: common/oscsel_consts.svh */
// constants for the oscillator source select block
`ifndef OSCSEL_CONSTS_SVH
`define OSCSEL_CONSTS_SVH

// ============================================================
// register map (byte addresses)
`define OSCSEL_CTRL_OFS        12'h000
`define OSCSEL_STAT_OFS        12'h004
`define OSCSEL_FAST_RC_OFS     12'h008

// ============================================================
// clock control register fields
`define OSCSEL_TRIM_HI_MSB     15
`define OSCSEL_TRIM_HI_LSB     14
`define OSCSEL_CUR_GRP_MSB     13
`define OSCSEL_CUR_GRP_LSB     12
`define OSCSEL_TRIM_LO_MSB     11
`define OSCSEL_TRIM_LO_LSB     10
`define OSCSEL_NEW_GRP_MSB     9
`define OSCSEL_NEW_GRP_LSB     8
`define OSCSEL_LOCK_BIT        5
`define OSCSEL_SEC_EN_BIT      1

// ============================================================
// status register fields
`define OSCSEL_ST_RELEASED_BIT 0
`define OSCSEL_ST_LOW_POWER_RC_ON_BIT  1
`define OSCSEL_ST_SEC_RUN_BIT  2
`define OSCSEL_ST_COUNTING_BIT 3

// ============================================================
// group codes
`define OSCSEL_GRP_SEC         2'h0
`define OSCSEL_GRP_FAST_RC     2'h1
`define OSCSEL_GRP_LOW_POWER_RC        2'h2
`define OSCSEL_GRP_PRIMARY     2'h3

// ============================================================
// reset values and timing
`define OSCSEL_TRIM_RST        4'h0
`define OSCSEL_STARTUP_CYCLES  11'h400
`define OSCSEL_LOW_POWER_RC_KHZ        512
`define OSCSEL_FAST_RC_KHZ     7370
`define OSCSEL_TRIM_STEP_PERMIL 15

`endif

/* File: common/oscsel_pkg.sv */
// types for the oscillator source select block
package oscsel_pkg;

  // ============================================================
  // primary oscillator modes
  typedef enum {
    OSCSEL_M_EXT,
    OSCSEL_M_EXT_IO,
    OSCSEL_M_EXT_PLL,
    OSCSEL_M_RC,
    OSCSEL_M_RC_IO,
    OSCSEL_M_XTAL,
    OSCSEL_M_XTAL_PLL,
    OSCSEL_M_XTAL_LOW,
    OSCSEL_M_XTAL_HS,
    OSCSEL_M_BAD
  } oscsel_mode_t;

  // ============================================================
  // function of the second oscillator pin
  typedef enum logic [1:0] {
    OSCSEL_P2_CLKDIV4 = 2'h0,
    OSCSEL_P2_GPIO    = 2'h1,
    OSCSEL_P2_XDRIVE  = 2'h2
  } oscsel_pin2_t;

  // ============================================================
  // start-up counter states
  typedef enum {
    OSCSEL_S_IDLE,
    OSCSEL_S_COUNT,
    OSCSEL_S_RUN
  } oscsel_st_t;

endpackage

/* File: common/oscsel_ost_if.sv */
// start-up counter control and status bundle
`timescale 1ns/1ns
interface oscsel_ost_if;
  logic start;
  logic osc_tick;
  logic counting;
  logic done;

  modport ctrl (output start, output osc_tick, input counting, input done);
  modport tmr  (input start, input osc_tick, output counting, output done);
endinterface

/* File: hw/oscsel_startup_timer.sv */
// start-up counter that holds a crystal clock until it is stable
`timescale 1ns/1ns
`include "oscsel_consts.svh"
module oscsel_startup_timer
  import oscsel_pkg::*;
#(
  parameter int CNT_W = 10
) (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst_n,    // async reset, active low
  oscsel_ost_if.tmr ost       // control from the selector
);

  oscsel_st_t       state_r;
  logic [CNT_W-1:0] cnt_r;

  // ============================================================
  // counting: all ones then one more tick marks the full count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= OSCSEL_S_IDLE;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        OSCSEL_S_IDLE: begin
          if (ost.start) begin
            state_r <= OSCSEL_S_COUNT;
            cnt_r   <= '0;
          end
        end
        OSCSEL_S_COUNT: begin
          if (ost.start) begin
            cnt_r <= '0;
          end else if (ost.osc_tick) begin
            cnt_r <= cnt_r + 1'b1;
            if (&cnt_r) begin
              state_r <= OSCSEL_S_RUN;
            end
          end
        end
        OSCSEL_S_RUN: begin
          if (ost.start) begin
            state_r <= OSCSEL_S_COUNT;
            cnt_r   <= '0;
          end
        end
        default: state_r <= OSCSEL_S_IDLE;
      endcase
    end
  end

  assign ost.counting = (state_r == OSCSEL_S_COUNT);
  assign ost.done     = (state_r == OSCSEL_S_RUN);

endmodule

/* File: sim/oscsel_osc_model.sv */
// behavioural external oscillator with pll lock indication
`timescale 1ns/1ns
module oscsel_osc_model (
  input  wire logic       clk_sys,   // system clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic [3:0] div,       // idle cycles between ticks
  input  wire logic       pll_en,    // pll in use
  input  wire logic       lose_lock, // noise knocks the loop out
  output logic            osc_tick,  // one pulse per oscillator cycle
  output logic            pll_locked // loop in lock
);
  logic [3:0] ph_r;
  logic [5:0] lk_r;

  // ============================================================
  // oscillator and lock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph_r     <= 4'h0;
      osc_tick <= 1'b0;
    end else begin
      ph_r     <= (ph_r >= div) ? 4'h0 : ph_r + 4'h1;
      osc_tick <= (ph_r >= div);
    end
  end

  // lock takes many cycles to gain but is lost at once
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lk_r <= 6'h0;
    end else if (!pll_en || lose_lock) begin
      lk_r <= 6'h0;
    end else if (osc_tick && lk_r != 6'h3f) begin
      lk_r <= lk_r + 6'h1;
    end
  end
  assign pll_locked = (lk_r == 6'h3f);
endmodule

/* File: sim/oscsel_top_assertions.sv */
// concurrent checks on the oscillator source select ports
`timescale 1ns/1ns
module oscsel_chk (
  input wire logic        clk_sys,            // clock
  input wire logic        rst_n,              // reset
  input wire logic        por_bor_pulse,      // load event
  input wire logic        sleep_wake,         // wake event
  input wire logic [1:0]  group_select_cfg,   // group field
  input wire logic [3:0]  primary_choice_cfg, // primary field
  input wire logic        osc_tick,           // osc pulse
  input wire logic        powerup_expired,    // timer done
  input wire logic        psel,               // apb
  input wire logic        penable,            // apb
  input wire logic        pready,             // apb
  input wire logic        pslverr,            // apb
  input wire logic [31:0] prdata,             // apb
  input wire logic        osc_clk_release,    // clock passed
  input wire logic        pll_enable,         // pll on
  input wire logic [4:0]  pll_gain,           // multiplier
  input wire logic        low_power_rc_run,           // low_power_rc on
  input wire logic        osc_in_gpio_en,     // pin 1 gpio
  input wire logic        osc_out_drv_n,      // pin 2 enable
  input wire logic [1:0]  osc_out_func        // pin 2 use
);
  logic [1:0]  grp_r;
  logic [3:0]  pc_r;
  logic [1:0]  age_r;
  logic [10:0] tk_r;
  logic        xtal_w;
  logic [1:0]  func_w;

  // ============================================================
  // helper state
  assign xtal_w = (grp_r == 2'h0) || (grp_r == 2'h3 && !pc_r[3]);
  assign func_w = !pc_r[3] ? 2'h2 : (pc_r == 4'hb || pc_r == 4'h9) ? 2'h0 : 2'h1;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      grp_r <= 2'h1;
      pc_r  <= 4'h0;
    end else if (por_bor_pulse) begin
      grp_r <= group_select_cfg;
      pc_r  <= primary_choice_cfg;
    end
  end
  // outputs settle a few cycles after a load
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) age_r <= 2'h3;
    else if (por_bor_pulse) age_r <= 2'h0;
    else if (age_r != 2'h3) age_r <= age_r + 2'h1;
  end
  // saturates at 1024 so a long run never wraps
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) tk_r <= 11'h0;
    else if (por_bor_pulse || sleep_wake) tk_r <= 11'h0;
    else if (osc_tick && !tk_r[10]) tk_r <= tk_r + 11'h1;
  end

  // ============================================================
  // assertions
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_load_plain;
    por_bor_pulse ##1 !xtal_w;
  endsequence
  sequence s_count_done;
    xtal_w && $rose(tk_r[10]);
  endsequence

  a_gpio_never: assert property (osc_in_gpio_en == 1'b0)
    else $error("first pin offered as gpio");
  a_low_power_rc_start: assert property (!powerup_expired |=> low_power_rc_run)
    else $error("low_power_rc off before power-up timer end");
  a_pll_gain: assert property (age_r == 2'h3 |->
    pll_enable == (grp_r == 2'h3 && pc_r[2] && pc_r[1:0] != 2'h0) &&
    pll_gain == ((pc_r[1:0] == 2'h0) ? 5'h1 : 5'h1 << (pc_r[1:0] + 3'h1)))
    else $error("pll gain wrong for choice");
  a_pin2_func: assert property (age_r == 2'h3 && pc_r != 4'ha |-> osc_out_func == func_w)
    else $error("second pin function wrong");
  a_pin2_drive: assert property (osc_out_drv_n == (osc_out_func != 2'h0))
    else $error("second pin drive wrong");
  a_xtal_hold: assert property ($rose(osc_clk_release) && xtal_w |-> tk_r[10])
    else $error("crystal clock released early");
  a_xtal_free: assert property (s_count_done |-> ##[0:8] osc_clk_release)
    else $error("crystal clock not released");
  a_plain_rel: assert property (s_load_plain |-> ##[0:3] osc_clk_release)
    else $error("plain clock held back");
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_apb_err: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error read carries data");
endmodule

bind oscsel_top oscsel_chk u_chk (
  .clk_sys, .rst_n, .por_bor_pulse, .sleep_wake, .group_select_cfg, .primary_choice_cfg,
  .osc_tick, .powerup_expired, .psel, .penable, .pready, .pslverr, .prdata,
  .osc_clk_release, .pll_enable, .pll_gain, .low_power_rc_run, .osc_in_gpio_en, .osc_out_drv_n,
  .osc_out_func
);

/* File: sim/tb_oscillator_source_select.sv */
// self-checking bench for the oscillator source select block
`timescale 1ns/1ns
`include "oscsel_consts.svh"
module tb_oscillator_source_select;
  logic        clk_sys, rst_n, por_bor_pulse, sleep_wake, sleep_active, osc_tick, pll_locked;
  logic        powerup_expired, fsm_enabled, wdt_enabled, psel, penable, pwrite, lose_lock;
  logic        pready, pslverr, osc_clk_release, pll_enable, sec_osc_run, low_power_rc_run, er;
  logic        osc_in_gpio_en, osc_out_drv_n, sec_en;
  logic [1:0]  group_select_cfg, clk_src_sel, osc_out_func, cur_g;
  logic [3:0]  primary_choice_cfg, fast_rc_trim_out, div;
  logic [4:0]  pll_gain;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_fail, checked;

  oscsel_top uut (.clk_sys, .rst_n, .por_bor_pulse, .sleep_wake, .sleep_active,
    .group_select_cfg, .primary_choice_cfg, .osc_tick, .pll_locked, .powerup_expired,
    .fsm_enabled, .wdt_enabled, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .clk_src_sel, .osc_clk_release, .pll_enable, .pll_gain, .sec_osc_run,
    .low_power_rc_run, .fast_rc_trim_out, .osc_in_gpio_en, .osc_out_drv_n, .osc_out_func);
  oscsel_osc_model u_osc (.clk_sys, .rst_n, .div, .pll_en(pll_enable), .lose_lock,
    .osc_tick, .pll_locked);

  // ============================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tmo;
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one idle cycle after each transfer keeps psel to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    i = 0;
    do begin
      cyc(1);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) tmo();
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(er, a > 12'h008);
    chk(q & m, e);
  endtask
  task automatic rel;
    int i;
    for (i = 0; i < 9000 && osc_clk_release !== 1'b1; i++) cyc(1);
    if (i == 9000) tmo();
  endtask
  task automatic wake(input logic e);
    sleep_wake <= 1'b1;
    cyc(1);
    sleep_wake <= 1'b0;
    cyc(4);
    chk(osc_clk_release, e);
    rel();
  endtask
  function automatic logic [8:0] pin_exp(input logic [1:0] g, input logic [3:0] p);
    logic       pll;
    logic [1:0] f;
    pll = (g == 2'h3) && p[2] && (p[1:0] != 2'h0);
    f = !p[3] ? 2'h2 : (p == 4'hb || p == 4'h9) ? 2'h0 : 2'h1;
    return {f, f != 2'h0, pll, ((p[1:0] == 2'h0) ? 5'h1 : 5'h1 << (p[1:0] + 3'h1))};
  endfunction
  task automatic por(input logic [1:0] g, input logic [3:0] p);
    group_select_cfg <= g;
    primary_choice_cfg <= p;
    por_bor_pulse <= 1'b1;
    cur_g = g;
    cyc(1);
    por_bor_pulse <= 1'b0;
    cyc(4);
    if (g == 2'h0 || (g == 2'h3 && !p[3])) chk(osc_clk_release, 1'b0);
    rel();
    chk({osc_out_func, osc_out_drv_n, pll_enable, pll_gain}, pin_exp(g, p));
    chk(clk_src_sel, (g == 2'h0 && !sec_en) ? 2'h1 : g);
    rd(`OSCSEL_CTRL_OFS, 32'h3300, {18'h0, g, 2'h0, g, 8'h0});
  endtask

  // ============================================================
  // stimulus
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    tmo();
  end
  initial begin
    logic [3:0] t;
    int         k;
    {rst_n, por_bor_pulse, sleep_wake, sleep_active, psel, penable, pwrite} = '0;
    {powerup_expired, fsm_enabled, wdt_enabled, lose_lock, sec_en} = '0;
    group_select_cfg = 2'h1;
    primary_choice_cfg = 4'h0;
    paddr = '0;
    pwdata = '0;
    div = 4'h1;
    n_fail = 0;
    checked = 0;
    void'($urandom(32'h88d79923));
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
    chk(low_power_rc_run, 1'b1);
    rd(`OSCSEL_CTRL_OFS, 32'hff22, 32'h1100);
    rd(12'h00c, 32'hffffffff, 32'h0);
    apb(1'b1, 12'h010, 32'hffffffff);
    chk(er, 1'b1);
    for (k = 0; k < 16; k++) begin
      div <= 4'($urandom_range(2));
      if (k != 10) por(2'h3, 4'(k));
    end
    for (k = 0; k < 4; k++) begin
      t = 4'($urandom);
      if (t == 4'ha) t = 4'h4;
      por(2'($urandom_range(2, 1)), t);
    end
    // secondary crystal, kept running while asleep
    sleep_active <= 1'b1;
    apb(1'b1, `OSCSEL_CTRL_OFS, 32'h2);
    sec_en = 1'b1;
    cyc(1);
    chk(sec_osc_run, 1'b1);
    rd(`OSCSEL_STAT_OFS, 32'h4, 32'h4);
    div <= 4'h3;
    por(2'h0, 4'h8);
    chk(sec_osc_run, 1'b1);
    apb(1'b1, `OSCSEL_CTRL_OFS, 32'h0);
    sec_en = 1'b0;
    cyc(1);
    chk({sec_osc_run, clk_src_sel}, 3'h1);
    sleep_active <= 1'b0;
    // trim corners then random values, read-only group bits written high
    for (k = 0; k < 8; k++) begin
      t = (k == 0) ? 4'h7 : (k == 1) ? 4'h8 : 4'($urandom);
      apb(1'b1, `OSCSEL_CTRL_OFS, {16'h0, t[3:2], 2'h3, t[1:0], 2'h3, 8'h0});
      cyc(1);
      chk(fast_rc_trim_out, t);
      rd(`OSCSEL_CTRL_OFS, 32'hff00, {16'h0, t[3:2], cur_g, t[1:0], cur_g, 8'h0});
      rd(`OSCSEL_FAST_RC_OFS, 32'hffffffff, {{28{t[3]}}, t} * 32'd15);
    end
    div <= 4'h0;
    por(2'h3, 4'h7);
    rd(`OSCSEL_CTRL_OFS, 32'h20, 32'h20);
    lose_lock <= 1'b1;
    cyc(2);
    rd(`OSCSEL_CTRL_OFS, 32'h20, 32'h0);
    lose_lock <= 1'b0;
    wake(1'b0);
    por(2'h3, 4'hb);
    wake(1'b1);
    powerup_expired <= 1'b1;
    for (k = 0; k < 4; k++) begin
      {wdt_enabled, fsm_enabled} <= 2'(k);
      cyc(3);
      chk(low_power_rc_run, k != 0);
    end
    {wdt_enabled, fsm_enabled} <= 2'h0;
    por(2'h2, 4'h1);
    chk(low_power_rc_run, 1'b1);
    end_sim();
  end
endmodule
